/* rtl/srwp_defines.svh */
// constants for the supervisor reset and write-protect block
`ifndef SRWP_DEFINES_SVH
`define SRWP_DEFINES_SVH

`define SRWP_OFF_CTRL 12'h000
`define SRWP_OFF_STATUS 12'h004
`define SRWP_OFF_IRQ_STAT 12'h008
`define SRWP_OFF_IRQ_MASK 12'h00c
`define SRWP_OFF_HOLD0 12'h010
`define SRWP_OFF_HOLD1 12'h014
`define SRWP_OFF_HOLD2 12'h018
`define SRWP_OFF_HOLD3 12'h01c

`define SRWP_CTRL_SEL_LO 0
`define SRWP_CTRL_SEL_HI 1
`define SRWP_CTRL_BP_LO 2
`define SRWP_CTRL_BP_HI 3

`define SRWP_EV_RESET 0
`define SRWP_EV_SECOND 1
`define SRWP_EV_REJECT 2

`define SRWP_CTRL_RST 4'h0
`define SRWP_MASK_RST 3'h0

// hold times in us, counts derived at 20 MHz
`define SRWP_CLK_MHZ 20
`define SRWP_HOLD0_US 50
`define SRWP_HOLD1_US 100
`define SRWP_HOLD2_US 200
`define SRWP_HOLD3_US 400
`define SRWP_HOLD0_CYC (`SRWP_HOLD0_US * `SRWP_CLK_MHZ)
`define SRWP_HOLD1_CYC (`SRWP_HOLD1_US * `SRWP_CLK_MHZ)
`define SRWP_HOLD2_CYC (`SRWP_HOLD2_US * `SRWP_CLK_MHZ)
`define SRWP_HOLD3_CYC (`SRWP_HOLD3_US * `SRWP_CLK_MHZ)

`endif

/* rtl/srwp_pkg.sv */
// types for the supervisor reset and write-protect block
package srwp_pkg;

  typedef enum logic [1:0] {
    SRWP_POWERUP = 2'b00,
    SRWP_ASSERT = 2'b01,
    SRWP_HOLD = 2'b10,
    SRWP_RUN = 2'b11
  } srwp_state_t;

  typedef struct packed {
    logic nv;
    logic vol;
  } srwp_wreq_t;

  typedef struct packed {
    logic manual;
    logic wp;
    logic below_trip;
    logic second;
    logic supply_ok;
  } srwp_pins_t;

endpackage

/* rtl/srwp_top.sv */
// supervisor reset sequencer and write-protect gate with apb registers
`timescale 1ns/10ps
`default_nettype none
`include "srwp_defines.svh"

// Notes on behaviour
// - wp high blocks all nonvolatile writes
// - wp plus nonzero block bits blocks all writes
// - undriven wp reads as low
// - manual reset high starts reset cycle
// - hold reset after manual reset releases
// - software selects hold time by two bits
// - power-up reset held after supply stable
// - reset high while supply below trip
// - second flag follows second comparator level
// - second flag has no hold timer
// - serial data receiver always enabled
module srwp_top import srwp_pkg::*; #(
  parameter logic [15:0] HOLD0 = 16'(`SRWP_HOLD0_CYC),
  parameter logic [15:0] HOLD1 = 16'(`SRWP_HOLD1_CYC),
  parameter logic [15:0] HOLD2 = 16'(`SRWP_HOLD2_CYC),
  parameter logic [15:0] HOLD3 = 16'(`SRWP_HOLD3_CYC)
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire srwp_pins_t pins,
  input wire logic wp_driven,
  input wire logic sda_in,
  input wire srwp_wreq_t wreq,
  output srwp_wreq_t wgrant,
  output logic supply_reset,
  output logic second_monitor_flag,
  output logic sda_seen,
  output logic irq,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // three stages; a change counts once stages two and three agree
  srwp_pins_t raw;
  srwp_pins_t s1_q, s2_q, s3_q, clean_q;
  logic sda1_q, sda2_q, sda3_q;

  // wp_driven low stands for the pull-down: a floating pin reads low
  always_comb begin
    raw = pins;
    raw.wp = pins.wp & wp_driven;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      clean_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < $bits(srwp_pins_t); i++) begin
        if (s2_q[i] == s3_q[i]) begin
          clean_q[i] <= s3_q[i];
        end
      end
    end
  end

  // receiver sampled every cycle regardless of state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sda1_q <= 1'b1;
      sda2_q <= 1'b1;
      sda3_q <= 1'b1;
      sda_seen <= 1'b1;
    end else begin
      sda1_q <= sda_in;
      sda2_q <= sda1_q;
      sda3_q <= sda2_q;
      if (sda2_q == sda3_q) begin
        sda_seen <= sda3_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  logic [3:0] ctrl_q;
  logic [2:0] irq_stat_q, irq_mask_q;
  logic wr_acc, rd_acc;
  logic [1:0] sel;
  logic [1:0] block_bits;

  // writes land only at the access edge that pready acknowledges
  assign wr_acc = psel & penable & pwrite & pready;
  assign rd_acc = psel & penable & ~pwrite;
  assign sel = ctrl_q[`SRWP_CTRL_SEL_HI:`SRWP_CTRL_SEL_LO];
  assign block_bits = ctrl_q[`SRWP_CTRL_BP_HI:`SRWP_CTRL_BP_LO];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q <= `SRWP_CTRL_RST;
    end else if (wr_acc && paddr == `SRWP_OFF_CTRL && !(clean_q.wp && block_bits != 2'b00)) begin
      ctrl_q <= pwdata[3:0];
    end
  end

  // ---------------------------------------------------------------
  // reset sequencer
  // ---------------------------------------------------------------
  srwp_state_t state_q;
  logic [15:0] cnt_q;
  logic [15:0] limit;
  logic force_rst;

  always_comb begin
    unique case (sel)
      2'b00: limit = HOLD0;
      2'b01: limit = HOLD1;
      2'b10: limit = HOLD2;
      2'b11: limit = HOLD3;
    endcase
  end

  assign force_rst = clean_q.manual | clean_q.below_trip;

  // hold lasts limit cycles; the output flop adds one more
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= SRWP_POWERUP;
      cnt_q <= 16'h0000;
    end else begin
      unique case (state_q)
        SRWP_POWERUP: begin
          cnt_q <= 16'h0000;
          if (clean_q.supply_ok) begin
            state_q <= SRWP_HOLD;
          end
        end
        SRWP_ASSERT: begin
          cnt_q <= 16'h0000;
          if (!force_rst) begin
            state_q <= SRWP_HOLD;
          end
        end
        SRWP_HOLD: begin
          if (force_rst) begin
            state_q <= SRWP_ASSERT;
            cnt_q <= 16'h0000;
          end else if (cnt_q + 16'h0001 >= limit) begin
            state_q <= SRWP_RUN;
          end else begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        SRWP_RUN: begin
          if (force_rst) begin
            state_q <= SRWP_ASSERT;
          end
        end
      endcase
      if (!clean_q.supply_ok && state_q != SRWP_POWERUP) begin
        state_q <= SRWP_POWERUP;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      supply_reset <= 1'b1;
    end else begin
      supply_reset <= (state_q != SRWP_RUN) || force_rst;
    end
  end

  // ---------------------------------------------------------------
  // second monitor and write gate
  // ---------------------------------------------------------------
  logic lock_all;
  logic rejected;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      second_monitor_flag <= 1'b0;
    end else begin
      second_monitor_flag <= clean_q.second;
    end
  end

  assign lock_all = clean_q.wp && block_bits != 2'b00;
  assign rejected = (wreq.nv && clean_q.wp) || (wreq.vol && lock_all);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wgrant <= '0;
    end else begin
      wgrant.nv <= wreq.nv & ~clean_q.wp;
      wgrant.vol <= wreq.vol & ~lock_all;
    end
  end

  // ---------------------------------------------------------------
  // interrupts and apb
  // ---------------------------------------------------------------
  logic [2:0] ev;
  logic rst_q;
  logic sec_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rst_q <= 1'b1;
      sec_q <= 1'b0;
    end else begin
      rst_q <= supply_reset;
      sec_q <= second_monitor_flag;
    end
  end

  always_comb begin
    ev = 3'h0;
    ev[`SRWP_EV_RESET] = supply_reset & ~rst_q;
    ev[`SRWP_EV_SECOND] = second_monitor_flag ^ sec_q;
    ev[`SRWP_EV_REJECT] = rejected;
  end

  // set wins over write-one-to-clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_stat_q <= 3'h0;
      irq_mask_q <= `SRWP_MASK_RST;
    end else begin
      if (wr_acc && paddr == `SRWP_OFF_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~pwdata[2:0]) | ev;
      end else begin
        irq_stat_q <= irq_stat_q | ev;
      end
      if (wr_acc && paddr == `SRWP_OFF_IRQ_MASK) begin
        irq_mask_q <= pwdata[2:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // no wait state: pready rises in the first access cycle, read data with it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable) begin
        unique case (paddr)
          `SRWP_OFF_CTRL: prdata <= {28'h0, ctrl_q};
          `SRWP_OFF_STATUS: prdata <= {25'h0, state_q, clean_q};
          `SRWP_OFF_IRQ_STAT: prdata <= {29'h0, irq_stat_q};
          `SRWP_OFF_IRQ_MASK: prdata <= {29'h0, irq_mask_q};
          `SRWP_OFF_HOLD0: prdata <= {16'h0, HOLD0};
          `SRWP_OFF_HOLD1: prdata <= {16'h0, HOLD1};
          `SRWP_OFF_HOLD2: prdata <= {16'h0, HOLD2};
          `SRWP_OFF_HOLD3: prdata <= {16'h0, HOLD3};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  nv_block_a: assert property (@(posedge ref_clk) disable iff (rst)
    (wreq.nv && clean_q.wp) |=> !wgrant.nv) else $error("nv write granted under wp");
  vol_block_a: assert property (@(posedge ref_clk) disable iff (rst)
    (wreq.vol && lock_all) |=> !wgrant.vol) else $error("volatile write granted when locked");
  wp_float_a: assert property (@(posedge ref_clk) disable iff (rst)
    !wp_driven [*4] |=> !clean_q.wp) else $error("floating wp seen as high");
  manual_rst_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(clean_q.manual) |=> supply_reset) else $error("manual reset not asserted");
  hold_after_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q == SRWP_ASSERT && !force_rst) |=> supply_reset [*2]) else $error("reset released early");
  sel_limit_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q == SRWP_HOLD && !force_rst && $stable(sel)) |-> cnt_q < limit)
    else $error("hold count passed limit");
  powerup_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q == SRWP_POWERUP) |=> supply_reset) else $error("reset low during power-up");
  brownout_a: assert property (@(posedge ref_clk) disable iff (rst)
    clean_q.below_trip |=> supply_reset) else $error("reset low during brown-out");
  second_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 second_monitor_flag == $past(clean_q.second)) else $error("second flag mismatch");
  irq_level_a: assert property (@(posedge ref_clk) disable iff (rst)
    |(irq_stat_q & irq_mask_q) |=> irq) else $error("interrupt not raised");
  apb_ready_a: assert property (@(posedge ref_clk) disable iff (rst)
    (psel && !penable) |=> pready) else $error("apb answer late");
  // pin, bus, gate, sequencer and interrupt checks
  nv_grant_a: assert property (@(posedge ref_clk) disable iff (rst)
    (wreq.nv && !clean_q.wp) |=> wgrant.nv) else $error("nv write refused without wp");
  vol_grant_a: assert property (@(posedge ref_clk) disable iff (rst)
    (wreq.vol && !lock_all) |=> wgrant.vol) else $error("volatile write refused unlocked");
  ctrl_lock_a: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_acc && paddr == `SRWP_OFF_CTRL && lock_all) |=> $stable(ctrl_q))
    else $error("control written while locked");
  powerup_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q == SRWP_POWERUP && clean_q.supply_ok) |=> state_q == SRWP_HOLD)
    else $error("power-up hold not started");
  run_entry_a: assert property (@(posedge ref_clk) disable iff (rst)
    ($rose(state_q == SRWP_RUN) && $stable(sel)) |-> $past(cnt_q) == limit - 16'h0001)
    else $error("hold count not at limit");
  reset_fall_a: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(supply_reset) |-> $past(state_q) == SRWP_RUN)
    else $error("reset released outside run");
  second_direct_a: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(clean_q.second) |=> $changed(second_monitor_flag))
    else $error("second flag delayed");
  sda_live_a: assert property (@(posedge ref_clk) disable iff (rst)
    (sda2_q == sda3_q) |=> sda_seen == $past(sda3_q))
    else $error("receiver not following line");
  reject_irq_a: assert property (@(posedge ref_clk) disable iff (rst)
    rejected |=> irq_stat_q[`SRWP_EV_REJECT]) else $error("reject event lost");

  manual_cycle_c: cover property (@(posedge ref_clk) disable iff (rst)
    state_q == SRWP_ASSERT ##1 state_q == SRWP_HOLD);
  release_c: cover property (@(posedge ref_clk) disable iff (rst) $fell(supply_reset));
  reject_c: cover property (@(posedge ref_clk) disable iff (rst) rejected);
  busy_line_c: cover property (@(posedge ref_clk) disable iff (rst) supply_reset && !sda_seen);
  locked_write_c: cover property (@(posedge ref_clk) disable iff (rst) wr_acc && lock_all);

endmodule
`default_nettype wire

/* test/srwp_bus_model.sv */
// serial bus master model: clock and data for the sda receiver
`timescale 1ns/10ps
`default_nettype none
module srwp_bus_model (
  input wire logic ref_clk,
  input wire logic en,
  output logic scl,
  output logic sda
);
  logic [2:0] ph = 3'h0;
  logic [31:0] pat = 32'h5a3c96e1;
  logic scl_q = 1'b0;
  logic sda_q = 1'b1;
  assign scl = scl_q;
  assign sda = sda_q;
  // clock stands low between frames
  always @(posedge ref_clk) begin
    ph <= en ? ph + 3'h1 : 3'h0;
    scl_q <= en && ph inside {3'h3, 3'h4, 3'h5, 3'h6};
    if (!en) begin
      sda_q <= 1'b1; // released line goes to its pull-up
    end else if (ph == 3'h7) begin
      sda_q <= pat[0];
      pat <= {pat[0], pat[31:1]};
    end
  end
endmodule
`default_nettype wire

/* test/supervisor_reset_write_protect_tb.sv */
// self-checking bench for the supervisor reset and write-protect block
`timescale 1ns/10ps
`default_nettype none
module supervisor_reset_write_protect_tb import srwp_pkg::*;;
  logic ref_clk, rst, wp_driven, sda_in, scl, bus_en, w;
  srwp_pins_t pins;
  srwp_wreq_t wreq, wgrant;
  logic supply_reset, second_monitor_flag, sda_seen, irq;
  logic psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, lf;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;
  int hold_cyc[4] = '{6, 10, 14, 18};

  srwp_top #(.HOLD0(16'h6), .HOLD1(16'ha), .HOLD2(16'he), .HOLD3(16'h12)) i_dut (
    .ref_clk, .rst, .pins, .wp_driven, .sda_in, .wreq, .wgrant, .supply_reset,
    .second_monitor_flag, .sda_seen, .irq, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr);
  srwp_bus_model i_bus (.ref_clk, .en(bus_en), .scl, .sda(sda_in));

  // ----
  // helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, m, s, e);
    end
  endtask
  task end_of_test;
    if (fails == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rel(input int s);
    n = 0;
    while (supply_reset !== 1'b0 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    chk(n >= hold_cyc[s] && n <= hold_cyc[s] + 8, 1, "hold time");
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 8000) begin
      fails++;
      end_of_test;
    end
  end

  // ----
  // scenarios
  // ----
  initial begin
    rst = 1'b1;
    pins = '0;
    wp_driven = 1'b0;
    wreq = '0;
    bus_en = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    lf = 32'hcbed;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk(supply_reset, 1, "por");
    pins.supply_ok <= 1'b1;
    rel(0);
    apb(0, 12'h000, 0);
    chk(rd, 0, "ctrl reset");
    chk(er, 0, "ctrl slverr");
    apb(0, 12'h020, 0);
    chk(er, 1, "unmapped");
    for (int s = 0; s < 4; s++) begin
      apb(1, 12'h000, s);
      apb(0, 12'(16 + 4 * s), 0);
      chk(rd, hold_cyc[s], "limit");
      pins.manual <= 1'b1;
      repeat (10) @(posedge ref_clk);
      chk(supply_reset, 1, "manual");
      pins.manual <= 1'b0;
      rel(s);
    end
    pins.below_trip <= 1'b1;
    repeat (30) @(posedge ref_clk);
    chk(supply_reset, 1, "brownout");
    pins.below_trip <= 1'b0;
    rel(3);
    // receiver must stay live even while reset is held
    bus_en <= 1'b1;
    pins.manual <= 1'b1;
    repeat (8) begin
      @(posedge scl);
      repeat (3) @(posedge ref_clk);
      chk(sda_seen, sda_in, "sda");
    end
    bus_en <= 1'b0;
    pins.manual <= 1'b0;
    rel(3);
    for (int i = 0; i < 24; i++) begin
      lf = lfsr(lf);
      pins.wp <= 1'b0;
      repeat (6) @(posedge ref_clk);
      apb(1, 12'h000, {lf[3:2], 2'h0});
      pins.wp <= lf[4];
      wp_driven <= lf[5];
      wreq <= lf[7:6];
      repeat (8) @(posedge ref_clk);
      w = lf[4] & lf[5];
      chk(wgrant, {lf[7] & !w, lf[6] & !(w && lf[3:2] != 0)}, "gate");
      apb(1, 12'h000, 0);
      apb(0, 12'h000, 0);
      chk(rd[3:2], (w && lf[3:2] != 0) ? lf[3:2] : 2'h0, "lock");
    end
    apb(1, 12'h00c, 0);
    for (int i = 0; i < 6; i++) begin
      lf = lfsr(lf);
      pins.second <= lf[0];
      repeat (6) @(posedge ref_clk);
      chk(second_monitor_flag, lf[0], "flag");
    end
    apb(1, 12'h008, 7);
    pins.second <= !lf[0];
    repeat (6) @(posedge ref_clk);
    chk(irq, 0, "masked");
    apb(1, 12'h00c, 2);
    repeat (3) @(posedge ref_clk);
    chk(irq, 1, "irq");
    apb(0, 12'h008, 0);
    chk(rd[1], 1, "status");
    apb(1, 12'h008, 2);
    repeat (3) @(posedge ref_clk);
    chk(irq, 0, "cleared");
    end_of_test;
  end
endmodule
`default_nettype wire
